// ===== fic_defines.vh
// constants for the flash in-application control block
// assumes an APB slave with 32-bit words, 8-bit registers in the low byte
`ifndef FIC_DEFINES_VH
`define FIC_DEFINES_VH
`define FIC_OFF_WORD1_LOW   12'h000
`define FIC_OFF_WORD1_HIGH  12'h004
`define FIC_OFF_WORD2_LOW   12'h008
`define FIC_OFF_WORD2_HIGH  12'h00C
`define FIC_OFF_WORD3_LOW   12'h010
`define FIC_OFF_WORD3_HIGH  12'h014
`define FIC_OFF_OP_CTRL     12'h018
`define FIC_OFF_RST_PAT     12'h01C
`define FIC_OFF_TIM_BUF     12'h020
`define FIC_OFF_ADDR_LOW    12'h024
`define FIC_OFF_ADDR_HIGH   12'h028
`define FIC_OFF_FIRST_LOW   12'h02C
`define FIC_OFF_FIRST_HIGH  12'h030
`define FIC_BIT_ENABLED     7
`define FIC_BIT_TRIGGER     3
`define FIC_BIT_WINIT       2
`define FIC_BIT_RDEN        1
`define FIC_BIT_RINIT       0
`define FIC_BIT_TSEL        1
`define FIC_BIT_BCLR        0
`define FIC_MODE_WRITE      3'h0
`define FIC_MODE_ERASE      3'h1
`define FIC_MODE_READ       3'h3
`define FIC_MODE_UNLOCK     3'h6
`define FIC_RESET_PATTERN   8'h55
`define FIC_KEY1_LOW        8'h00
`define FIC_KEY2_LOW        8'h0D
`define FIC_KEY3_LOW        8'hC3
`define FIC_KEY1_HIGH       8'h04
`define FIC_KEY2_HIGH       8'h09
`define FIC_KEY3_HIGH       8'h40
`define FIC_CLK_MHZ         250
// program times in microseconds
`define FIC_ERASE_US_FAST   3200
`define FIC_WRITE_US_FAST   2200
`define FIC_ERASE_US_SLOW   3700
`define FIC_WRITE_US_SLOW   3000
`define FIC_UNLOCK_CYCLES   2000
`define FIC_READ_CYCLES     4
`define FIC_CLEAR_CYCLES    32
`endif

// ===== fic_timer.v
// one-shot down counter: loads on start, pulses done on the last count
// assumes start is a one-cycle pulse and load is at least one
`timescale 1ns/1ps
`default_nettype none
module fic_timer (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        start,
  input  wire        abort,
  input  wire [31:0] load,
  output wire        busy,
  output wire        done
);
  reg [31:0] count_reg;

  assign busy = (count_reg != 32'h0);
  assign done = (count_reg == 32'h1);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 32'h0;
    end else if (abort) begin
      count_reg <= 32'h0;
    end else if (start) begin
      count_reg <= load;
    end else if (count_reg != 32'h0) begin
      count_reg <= count_reg - 32'h1;
    end
  end
endmodule
`default_nettype wire

// ===== fic_flash_ctrl.v
// flash in-application control registers: unlock, mode, triggers, timing
// assumes an APB master on pclk; flash array sits behind the flash_* ports
//
// Notes on behaviour
// - enabled status set by hardware only
// - mode 000 write, 001 erase, 011 read, 110 unlock
// - trigger starts timer, cleared on expiry
// - write initiate starts process, self-clears
// - reads allowed only with read enable
// - read initiate starts read, self-clears
// - cpu stalled during active operation
// - 55H to reset pattern resets chip
// - select zero: erase 3.2ms, write 2.2ms
// - select one: erase 3.7ms, write 3.0ms
// - buffer clear bit self-clears when done
// - upper six timing bits read zero
// - unlock needs exact six key bytes
// - first word high write loads, increments address
// - address stops at page end 11111b
// - buffer auto-cleared after write
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fic_defines.vh"
module fic_flash_ctrl #(
  parameter UNLOCK_CYCLES = `FIC_UNLOCK_CYCLES,
  parameter ERASE_FAST    = `FIC_ERASE_US_FAST * `FIC_CLK_MHZ,
  parameter WRITE_FAST    = `FIC_WRITE_US_FAST * `FIC_CLK_MHZ,
  parameter ERASE_SLOW    = `FIC_ERASE_US_SLOW * `FIC_CLK_MHZ,
  parameter WRITE_SLOW    = `FIC_WRITE_US_SLOW * `FIC_CLK_MHZ
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire        cpu_stall,
  output reg         chip_reset_req,
  output reg         buf_load,
  output reg  [15:0] buf_data,
  output reg         buf_clear,
  output reg         flash_erase_go,
  output reg         flash_write_go,
  output reg         flash_read_go,
  output wire [13:0] flash_addr
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_ERASE = 2'h1;
  localparam ST_WRITE = 2'h2;
  localparam ST_READ  = 2'h3;

  reg [7:0]  w1l_reg;
  reg [7:0]  w1h_reg;
  reg [7:0]  w2l_reg;
  reg [7:0]  w2h_reg;
  reg [7:0]  w3l_reg;
  reg [7:0]  w3h_reg;
  reg        enabled_reg;
  reg [2:0]  mode_reg;
  reg        trigger_reg;
  reg        winit_reg;
  reg        rden_reg;
  reg        rinit_reg;
  reg [7:0]  rst_pat_reg;
  reg        tsel_reg;
  reg        bclr_reg;
  reg [7:0]  addr_low_reg;
  reg [5:0]  addr_high_reg;
  reg [7:0]  first_low_reg;
  reg [7:0]  first_high_reg;
  reg [1:0]  state_reg;
  reg [31:0] op_load;
  reg        op_start;

  wire       wr_acc = psel & penable & pwrite;
  wire [7:0] wd     = pwdata[7:0];
  // unmapped or unaligned addresses answer with an error and change nothing
  wire       hit    = (paddr <= `FIC_OFF_FIRST_HIGH) && (paddr[1:0] == 2'h0);
  wire       unl_done, op_done, clr_done;
  wire       key_ok;
  wire       end_write;

  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~hit;
  assign flash_addr = {addr_high_reg, addr_low_reg};
  assign cpu_stall = (state_reg != ST_IDLE);
  assign end_write = op_done & (state_reg == ST_WRITE);

  assign key_ok = (w1l_reg == `FIC_KEY1_LOW) && (w1h_reg == `FIC_KEY1_HIGH) &&
                  (w2l_reg == `FIC_KEY2_LOW) && (w2h_reg == `FIC_KEY2_HIGH) &&
                  (w3l_reg == `FIC_KEY3_LOW) && (w3h_reg == `FIC_KEY3_HIGH);

  wire wr_w1l  = wr_acc && (paddr == `FIC_OFF_WORD1_LOW);
  wire wr_w1h  = wr_acc && (paddr == `FIC_OFF_WORD1_HIGH);
  wire wr_w2l  = wr_acc && (paddr == `FIC_OFF_WORD2_LOW);
  wire wr_w2h  = wr_acc && (paddr == `FIC_OFF_WORD2_HIGH);
  wire wr_w3l  = wr_acc && (paddr == `FIC_OFF_WORD3_LOW);
  wire wr_w3h  = wr_acc && (paddr == `FIC_OFF_WORD3_HIGH);
  wire wr_ctl  = wr_acc && (paddr == `FIC_OFF_OP_CTRL);
  wire wr_pat  = wr_acc && (paddr == `FIC_OFF_RST_PAT);
  wire wr_tim  = wr_acc && (paddr == `FIC_OFF_TIM_BUF);
  wire wr_adl  = wr_acc && (paddr == `FIC_OFF_ADDR_LOW);
  wire wr_adh  = wr_acc && (paddr == `FIC_OFF_ADDR_HIGH);
  wire wr_fl   = wr_acc && (paddr == `FIC_OFF_FIRST_LOW);
  wire wr_fh   = wr_acc && (paddr == `FIC_OFF_FIRST_HIGH);

  // mode decode from the stored field; reserved codes start nothing
  wire mode_write = (mode_reg == `FIC_MODE_WRITE);
  wire mode_erase = (mode_reg == `FIC_MODE_ERASE);
  wire mode_read  = (mode_reg == `FIC_MODE_READ);
  wire op_idle    = (state_reg == ST_IDLE);

  // starts decoded from the control and timing writes; each refused while its own timer runs
  wire go_trig = wr_ctl && wd[`FIC_BIT_TRIGGER] && !trigger_reg &&
                 (wd[6:4] == `FIC_MODE_UNLOCK);
  wire go_w    = wr_ctl && wd[`FIC_BIT_WINIT] && op_idle && enabled_reg &&
                 (mode_write || mode_erase);
  wire go_r    = wr_ctl && wd[`FIC_BIT_RINIT] && op_idle && rden_reg &&
                 mode_read;
  wire go_clr  = wr_tim && wd[`FIC_BIT_BCLR] && !bclr_reg;

  // erase, write and read share one timer; the mode and select pick the count
  always @* begin
    op_start = 1'b0;
    op_load  = 32'h0;
    if (go_w && (mode_reg == `FIC_MODE_ERASE)) begin
      op_start = 1'b1;
      op_load  = tsel_reg ? ERASE_SLOW : ERASE_FAST;
    end else if (go_w) begin
      op_start = 1'b1;
      op_load  = tsel_reg ? WRITE_SLOW : WRITE_FAST;
    end else if (go_r) begin
      op_start = 1'b1;
      op_load  = `FIC_READ_CYCLES;
    end
  end

  // unlock window timer, erase/write/read timer and buffer clear timer
  fic_timer u_unlock (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (go_trig),
    .abort   (1'b0),
    .load    (UNLOCK_CYCLES),
    .busy    (),
    .done    (unl_done)
  );
  fic_timer u_op (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (op_start),
    .abort   (1'b0),
    .load    (op_load),
    .busy    (),
    .done    (op_done)
  );
  fic_timer u_clr (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (go_clr),
    .abort   (1'b0),
    .load    (`FIC_CLEAR_CYCLES),
    .busy    (),
    .done    (clr_done)
  );

  // plain storage; correct keys left from an earlier unlock enable at the next trigger
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w1l_reg       <= 8'h00;
      w1h_reg       <= 8'h00;
      w2l_reg       <= 8'h00;
      w2h_reg       <= 8'h00;
      w3l_reg       <= 8'h00;
      w3h_reg       <= 8'h00;
      rst_pat_reg   <= 8'h00;
      first_low_reg <= 8'h00;
    end else begin
      if (wr_w1l) w1l_reg <= wd;
      if (wr_w1h) w1h_reg <= wd;
      if (wr_w2l) w2l_reg <= wd;
      if (wr_w2h) w2h_reg <= wd;
      if (wr_w3l) w3l_reg <= wd;
      if (wr_w3h) w3h_reg <= wd;
      if (wr_pat) rst_pat_reg <= wd;
      if (wr_fl) first_low_reg <= wd;
    end
  end

  // control register: status, mode, self-clearing triggers and the process state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enabled_reg <= 1'b0;
      mode_reg    <= 3'h0;
      trigger_reg <= 1'b0;
      winit_reg   <= 1'b0;
      rden_reg    <= 1'b0;
      rinit_reg   <= 1'b0;
      state_reg   <= ST_IDLE;
    end else begin
      // hardware set wins over a software clear in the same cycle
      if (trigger_reg && key_ok) begin
        enabled_reg <= 1'b1;
      end else if (wr_ctl && !wd[`FIC_BIT_ENABLED]) begin
        enabled_reg <= 1'b0;
      end
      if (wr_ctl) begin
        mode_reg <= wd[6:4];
        rden_reg <= wd[`FIC_BIT_RDEN];
      end
      // the window closes on expiry whatever the keys hold
      if (go_trig) begin
        trigger_reg <= 1'b1;
      end else if (unl_done) begin
        trigger_reg <= 1'b0;
      end
      // initiate bits read high until their process ends, so software can poll
      if (go_w) begin
        winit_reg <= 1'b1;
      end else if (op_done && (state_reg != ST_READ)) begin
        winit_reg <= 1'b0;
      end
      if (go_r) begin
        rinit_reg <= 1'b1;
      end else if (op_done && (state_reg == ST_READ)) begin
        rinit_reg <= 1'b0;
      end
      // further initiates are refused until the running process ends
      if (op_start) begin
        state_reg <= go_r ? ST_READ :
                     ((mode_reg == `FIC_MODE_ERASE) ? ST_ERASE : ST_WRITE);
      end else if (op_done) begin
        state_reg <= ST_IDLE;
      end
    end
  end

  // timing select and buffer clear trigger; the other six bits do not exist
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tsel_reg <= 1'b0;
      bclr_reg <= 1'b0;
    end else begin
      if (wr_tim) tsel_reg <= wd[`FIC_BIT_TSEL];
      if (go_clr) begin
        bclr_reg <= 1'b1;
      end else if (clr_done) begin
        bclr_reg <= 1'b0;
      end
    end
  end

  // address load; a first-word high write also tags and steps the address
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_low_reg   <= 8'h00;
      addr_high_reg  <= 6'h00;
      first_high_reg <= 8'h00;
      buf_load       <= 1'b0;
      buf_data       <= 16'h0000;
    end else begin
      buf_load <= 1'b0;
      if (wr_fh) begin
        first_high_reg <= wd;
        buf_load       <= 1'b1;
        buf_data       <= {wd, first_low_reg};
        if (addr_low_reg[4:0] != 5'h1F) begin
          addr_low_reg[4:0] <= addr_low_reg[4:0] + 5'h01;
        end
      end else if (wr_adl) begin
        addr_low_reg <= wd;
      end
      if (wr_adh) addr_high_reg <= wd[5:0];
    end
  end

  // strobes to the flash array and the chip reset last exactly one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_reset_req <= 1'b0;
      buf_clear      <= 1'b0;
      flash_erase_go <= 1'b0;
      flash_write_go <= 1'b0;
      flash_read_go  <= 1'b0;
    end else begin
      buf_clear      <= clr_done | end_write;
      flash_erase_go <= go_w && mode_erase;
      flash_write_go <= go_w && mode_write;
      flash_read_go  <= go_r;
      chip_reset_req <= wr_pat && (wd == `FIC_RESET_PATTERN);
    end
  end

  // read data registered at the setup cycle so the slave needs no wait state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == `FIC_OFF_WORD1_LOW) begin
        prdata <= {24'h0, w1l_reg};
      end else if (paddr == `FIC_OFF_WORD1_HIGH) begin
        prdata <= {24'h0, w1h_reg};
      end else if (paddr == `FIC_OFF_WORD2_LOW) begin
        prdata <= {24'h0, w2l_reg};
      end else if (paddr == `FIC_OFF_WORD2_HIGH) begin
        prdata <= {24'h0, w2h_reg};
      end else if (paddr == `FIC_OFF_WORD3_LOW) begin
        prdata <= {24'h0, w3l_reg};
      end else if (paddr == `FIC_OFF_WORD3_HIGH) begin
        prdata <= {24'h0, w3h_reg};
      end else if (paddr == `FIC_OFF_OP_CTRL) begin
        prdata <= {24'h0, enabled_reg, mode_reg, trigger_reg, winit_reg, rden_reg,
                   rinit_reg};
      end else if (paddr == `FIC_OFF_RST_PAT) begin
        prdata <= {24'h0, rst_pat_reg};
      end else if (paddr == `FIC_OFF_TIM_BUF) begin
        prdata <= {30'h0, tsel_reg, bclr_reg};
      end else if (paddr == `FIC_OFF_ADDR_LOW) begin
        prdata <= {24'h0, addr_low_reg};
      end else if (paddr == `FIC_OFF_ADDR_HIGH) begin
        prdata <= {26'h0, addr_high_reg};
      end else if (paddr == `FIC_OFF_FIRST_LOW) begin
        prdata <= {24'h0, first_low_reg};
      end else if (paddr == `FIC_OFF_FIRST_HIGH) begin
        prdata <= {24'h0, first_high_reg};
      end else begin
        prdata <= 32'h0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== fic_flash_ctrl_sva.sv
// assertions on the flash control block's ports
// assumes one pclk domain and an asynchronous active-low presetn
`timescale 1ns/1ps
`default_nettype none
module fic_flash_ctrl_sva #(
  parameter ERASE_SLOW = 925000,
  parameter WRITE_SLOW = 750000
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cpu_stall,
  input wire logic        chip_reset_req,
  input wire logic        buf_load,
  input wire logic [15:0] buf_data,
  input wire logic        flash_erase_go,
  input wire logic        flash_write_go,
  input wire logic        flash_read_go,
  input wire logic [13:0] flash_addr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  localparam LONGEST = (ERASE_SLOW > WRITE_SLOW) ? ERASE_SLOW : WRITE_SLOW;
  wire logic wa;
  wire logic rst_wr;
  logic [31:0] stall_cnt;
  assign wa = psel && penable && pwrite;
  assign rst_wr = wa && paddr == 12'h01C && pwdata[7:0] == 8'h55;
  // the longest process bounds how long the cpu may be held
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) stall_cnt <= 32'h0;
    else stall_cnt <= cpu_stall ? stall_cnt + 32'h1 : 32'h0;
  end
  a_ready_always: assert property (pready) else $error("pready low");
  a_reset_pulse: assert property (rst_wr |=> chip_reset_req ##1 !chip_reset_req)
    else $error("no reset pulse");
  a_reset_cause: assert property (chip_reset_req |-> $past(rst_wr))
    else $error("stray reset pulse");
  a_err_map: assert property (psel && penable |->
    pslverr == (paddr > 12'h030 || paddr[1:0] != 2'b00))
    else $error("pslverr wrong");
  a_tim_upper: assert property (psel && !penable && !pwrite && paddr == 12'h020 |=>
    prdata[7:2] == 6'h00)
    else $error("upper bits not zero");
  a_load_word: assert property (buf_load |-> $past(wa && paddr == 12'h030) &&
    buf_data[15:8] == $past(pwdata[7:0]))
    else $error("buffer load wrong");
  a_addr_stop: assert property (wa && paddr == 12'h030 && flash_addr[4:0] == 5'h1F |=>
    flash_addr[4:0] == 5'h1F)
    else $error("address wrapped");
  a_stall_go: assert property (flash_erase_go || flash_write_go || flash_read_go |->
    cpu_stall)
    else $error("cpu not held");
  a_stall_bound: assert property (stall_cnt <= LONGEST + 8)
    else $error("stall too long");
  a_go_single: assert property (flash_write_go |=> !flash_write_go)
    else $error("write go too long");
  c_reset: cover property (chip_reset_req);
  c_read: cover property (flash_read_go);
  c_erase_write: cover property (flash_erase_go ##[1:1000] flash_write_go);
endmodule
bind fic_flash_ctrl fic_flash_ctrl_sva #(.ERASE_SLOW(ERASE_SLOW), .WRITE_SLOW(WRITE_SLOW))
  fic_flash_ctrl_sva_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cpu_stall(cpu_stall), .chip_reset_req(chip_reset_req), .buf_load(buf_load),
  .buf_data(buf_data), .flash_erase_go(flash_erase_go), .flash_write_go(flash_write_go),
  .flash_read_go(flash_read_go), .flash_addr(flash_addr));
`default_nettype wire

// ===== fic_flash_ctrl_tb.sv
// self-checking bench for the flash control block over APB
// assumes shortened process counts; the bench drives every input itself
`timescale 1ns/1ps
`default_nettype none
module fic_flash_ctrl_tb;
  localparam int EF = 100, WF = 120, ES = 160, WS = 200;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  wire logic [31:0] prdata;
  wire logic [15:0] buf_data;
  wire logic [13:0] flash_addr;
  wire logic   pready, pslverr, cpu_stall, chip_reset_req, buf_load, buf_clear;
  wire logic   flash_erase_go, flash_write_go, flash_read_go;
  int          n_mismatch, n_checks, n_rst, n_clr, n_rd, n_er, n_wr, i, c;
  int          tab[4] = '{EF, WF, ES, WS};
  logic [7:0]  q, md;
  logic        e;
  logic [15:0] last_buf;
  fic_flash_ctrl #(.UNLOCK_CYCLES(50), .ERASE_FAST(EF), .WRITE_FAST(WF), .ERASE_SLOW(ES),
    .WRITE_SLOW(WS)) fic_flash_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_stall(cpu_stall), .chip_reset_req(chip_reset_req), .buf_load(buf_load),
    .buf_data(buf_data), .buf_clear(buf_clear), .flash_erase_go(flash_erase_go),
    .flash_write_go(flash_write_go), .flash_read_go(flash_read_go), .flash_addr(flash_addr));
  initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end
  // pulse outputs last one cycle; counted mid-cycle, clear of the launching edge
  always @(negedge pclk) begin
    if (chip_reset_req === 1'b1) n_rst++;
    if (buf_clear === 1'b1) n_clr++;
    if (flash_read_go === 1'b1) n_rd++;
    if (flash_erase_go === 1'b1) n_er++;
    if (flash_write_go === 1'b1) n_wr++;
    if (buf_load === 1'b1) last_buf <= buf_data;
  end
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    begin
      n_checks++;
      if (g !== x) begin
        n_mismatch++;
        $display("[ERR] t=%0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  task automatic xfer(input bit w, input logic [11:0] a, input logic [7:0] d);
    int k;
    begin
      k = 0;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin n_mismatch++; tally_and_finish; end
      q = prdata[7:0];
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] x);
    begin xfer(1'b0, a, 8'h00); chk(q, x); end
  endtask
  // polls a self-clearing bit; c is the elapsed cycle count
  task automatic poll(input logic [11:0] a, input logic [7:0] m);
    time t0;
    int k;
    begin
      t0 = $time; k = 0;
      do begin xfer(1'b0, a, 8'h00); k++; end while ((q & m) !== 8'h00 && k < 400);
      if (k >= 400) begin n_mismatch++; tally_and_finish; end
      c = int'(($time - t0) / 4);
    end
  endtask
  task automatic unlock(input logic [7:0] last);
    begin
      wr(12'h018, 8'h68); wr(12'h000, 8'h00); wr(12'h004, 8'h04); wr(12'h008, 8'h0D);
      wr(12'h00C, 8'h09); wr(12'h010, 8'hC3); wr(12'h014, last);
    end
  endtask
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 13; i++) rdc(12'(4 * i), 8'h00);
    wr(12'h020, 8'hFF);
    poll(12'h020, 8'h01); chk(c <= 40, 1);
    rdc(12'h020, 8'h02); chk(n_clr, 1);
    wr(12'h018, 8'h80); rdc(12'h018, 8'h00);
    wr(12'h018, 8'h04); rdc(12'h018, 8'h00);
    unlock(8'h41); rdc(12'h018, 8'h68);
    poll(12'h018, 8'h08); chk(c <= 60, 1); rdc(12'h018, 8'h60);
    unlock(8'h40); poll(12'h018, 8'h08); rdc(12'h018, 8'hE0);
    wr(12'h024, 8'h1E); wr(12'h028, 8'h01); wr(12'h02C, 8'h34); wr(12'h030, 8'h12);
    chk(last_buf, 16'h1234); rdc(12'h024, 8'h1F);
    wr(12'h030, 8'h56); rdc(12'h024, 8'h1F); chk(flash_addr, 14'h011F);
    for (i = 0; i < 4; i++) begin
      wr(12'h020, {6'h00, i[1], 1'b0});
      md = i[0] ? 8'h80 : 8'h90;
      wr(12'h018, md); wr(12'h018, md | 8'h04);
      chk(cpu_stall, 1);
      poll(12'h018, 8'h04); chk(c >= tab[i] - 6 && c <= tab[i] + 6, 1);
      rdc(12'h018, md);
    end
    chk(n_er, 2); chk(n_wr, 2); chk(n_clr, 3);
    wr(12'h018, 8'h00); rdc(12'h018, 8'h00);
    wr(12'h018, 8'h30); wr(12'h018, 8'h31); rdc(12'h018, 8'h30); chk(n_rd, 0);
    wr(12'h018, 8'h32); wr(12'h018, 8'h33); poll(12'h018, 8'h01); chk(n_rd, 1);
    xfer(1'b0, 12'h034, 8'h00); chk(e, 1); chk(q, 8'h00);
    wr(12'h01C, 8'h54); chk(n_rst, 0); wr(12'h01C, 8'h55); rdc(12'h01C, 8'h55);
    chk(n_rst, 1);
    tally_and_finish;
  end
endmodule
`default_nettype wire
